// [design/remainder_out_cfg.svh]
/*
 * Constants for the CRC-32 generator/verifier and its register block:
 * register offsets, reset values, polynomial and residue.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef REMAINDER_OUT_CFG_SVH
`define REMAINDER_OUT_CFG_SVH

// register byte offsets
`define CRC_OFF_GEN_PRELOAD 8'h00
`define CRC_OFF_GEN_DATA    8'h04
`define CRC_OFF_GEN_LAST    8'h08
`define CRC_OFF_GEN_REM     8'h0c
`define CRC_OFF_VER_PRELOAD 8'h10
`define CRC_OFF_VER_DATA    8'h14
`define CRC_OFF_VER_LAST    8'h18
`define CRC_OFF_VER_REM     8'h1c
`define CRC_OFF_STATUS      8'h20
`define CRC_OFF_MASK        8'h24

// status / mask bit positions
`define CRC_STS_FINAL_BIT    0
`define CRC_STS_MATCH_BIT    1
`define CRC_STS_MISMATCH_BIT 2

// arithmetic constants and reset values
`define CRC_POLY       32'h04c11db7
`define CRC_RESIDUE    32'hc704dd7b
`define CRC_REM_RST    32'h00000000
`define CRC_MASK_RST   3'h0
`define CRC_RESP_OKAY  2'h0
`define CRC_RESP_SLVERR 2'h2

`endif

// [design/remainder_out_pkg.sv]
/*
 * Types and the shared word-fold function for the CRC-32 engine.
 * Assumes remainder_out_cfg.svh is on the include path.
 */
`include "remainder_out_cfg.svh"

package remainder_out_pkg;

    // one packet word with its qualifier and end-of-packet request
    typedef struct packed {
        logic [31:0] data;
        logic        valid;
        logic        last;
    } word_t;

    // sticky event bits
    typedef struct packed {
        logic mismatch;
        logic match;
        logic final_done;
    } events_t;

    // fold one 32-bit word into the remainder, msb first
    function automatic logic [31:0] fold(input logic [31:0] crc, input logic [31:0] data);
        logic [31:0] r;
        logic        fb;
        r = crc;
        for (int i = 31; i >= 0; i--)
        begin
            fb = r[31] ^ data[i];
            r  = {r[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction

endpackage

// [design/remainder_out_aal5_gen_verify.sv]
/*
 * CRC-32 generator and verifier for AAL-5 packets behind an AXI4-Lite
 * register slave, with sticky read-clear event status and a masked
 * interrupt. Assumes one clock (aclk) and a synchronous active-low reset.
 */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`include "remainder_out_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module remainder_out_gen
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire remainder_out_pkg::word_t word_in,
    input  wire logic             preload,
    input  wire logic [31:0]      preload_value,
    output logic [31:0]           remainder_out
);
    logic [31:0] crc_q;
    logic [31:0] crc_d;
    logic [31:0] out_d;

    // running remainder; output inverted only on the finalise word
    always_comb
    begin
        crc_d = crc_q;
        out_d = crc_q;
        if (preload)
        begin
            crc_d = preload_value;
            out_d = preload_value;
        end
        else if (word_in.valid)
        begin
            crc_d = remainder_out_pkg::fold(crc_q, word_in.data);
            out_d = word_in.last ? ~crc_d : crc_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            crc_q         <= `CRC_REM_RST;
            remainder_out <= `CRC_REM_RST;
        end
        else
        begin
            crc_q         <= crc_d;
            remainder_out <= out_d;
        end
    end
endmodule

module remainder_out_ver
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire remainder_out_pkg::word_t word_in,
    input  wire logic             preload,
    input  wire logic [31:0]      preload_value,
    output logic [31:0]           remainder,
    output logic                  residue_match
);
    logic [31:0] crc_d;
    logic        match_d;

    // the check word is folded before comparing, so it counts
    always_comb
    begin
        crc_d   = remainder;
        match_d = 1'b0;
        if (preload)
            crc_d = preload_value;
        else if (word_in.valid)
        begin
            crc_d   = remainder_out_pkg::fold(remainder, word_in.data);
            match_d = word_in.last && (crc_d == `CRC_RESIDUE);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            remainder     <= `CRC_REM_RST;
            residue_match <= 1'b0;
        end
        else
        begin
            remainder     <= crc_d;
            residue_match <= match_d;
        end
    end
endmodule

module remainder_out_aal5_gen_verify
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq
);
    // write channel state
    logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0]       wdata_q, wdata_d;
    logic [3:0]        wstrb_q, wstrb_d;
    logic              awready_d, wready_d, bvalid_d;
    logic [1:0]        bresp_d;
    // read channel state
    logic              arready_d, rvalid_d;
    logic [31:0]       rdata_d;
    logic [1:0]        rresp_d;
    // engine strobes, event status, mask
    remainder_out_pkg::word_t  gen_word_q, gen_word_d, ver_word_q, ver_word_d;
    logic              gen_pre_q, gen_pre_d, ver_pre_q, ver_pre_d;
    logic [31:0]       pre_val_q, pre_val_d;
    logic              chk_q, chk_d, fin_q, fin_d;
    remainder_out_pkg::events_t sts_q, sts_d, mask_q, mask_d, ev;
    logic              irq_d;
    logic [31:0]       gen_rem, ver_rem;
    logic              match;
    logic              do_write;
    logic [7:0]        wa, ra;

    function automatic logic mapped(input logic [7:0] a);
        return a == `CRC_OFF_GEN_PRELOAD || a == `CRC_OFF_GEN_DATA
            || a == `CRC_OFF_GEN_LAST || a == `CRC_OFF_GEN_REM
            || a == `CRC_OFF_VER_PRELOAD || a == `CRC_OFF_VER_DATA
            || a == `CRC_OFF_VER_LAST || a == `CRC_OFF_VER_REM
            || a == `CRC_OFF_STATUS || a == `CRC_OFF_MASK;
    endfunction

    function automatic logic [31:0] strobed(input logic [31:0] d, input logic [3:0] s);
        return d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // separate engines, each with its own word and preload strobe, sharing aclk and the preload value
    remainder_out_gen u_gen
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .word_in       (gen_word_q),
        .preload       (gen_pre_q),
        .preload_value (pre_val_q),
        .remainder_out (gen_rem)
    );

    remainder_out_ver u_ver
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .word_in       (ver_word_q),
        .preload       (ver_pre_q),
        .preload_value (pre_val_q),
        .remainder     (ver_rem),
        .residue_match (match)
    );

    assign wa = 8'(awaddr_q);
    assign ra = 8'(s_axi_araddr);
    assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

    // write path: address and data taken in either order, then one response
    always_comb
    begin
        aw_hold_d  = aw_hold_q;
        w_hold_d   = w_hold_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bvalid_d   = s_axi_bvalid;
        bresp_d    = s_axi_bresp;
        gen_word_d = '0;
        ver_word_d = '0;
        gen_pre_d  = 1'b0;
        ver_pre_d  = 1'b0;
        pre_val_d  = pre_val_q;
        mask_d     = mask_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_d = 1'b0;
        if (do_write)
        begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = mapped(wa) ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
            // one bus write is one word, so ordering after preload is kept
            case (wa)
                `CRC_OFF_GEN_PRELOAD:
                begin
                    gen_pre_d = 1'b1;
                    pre_val_d = strobed(wdata_q, wstrb_q);
                end
                `CRC_OFF_VER_PRELOAD:
                begin
                    ver_pre_d = 1'b1;
                    pre_val_d = strobed(wdata_q, wstrb_q);
                end
                `CRC_OFF_GEN_DATA: gen_word_d = '{strobed(wdata_q, wstrb_q), 1'b1, 1'b0};
                `CRC_OFF_GEN_LAST: gen_word_d = '{strobed(wdata_q, wstrb_q), 1'b1, 1'b1};
                `CRC_OFF_VER_DATA: ver_word_d = '{strobed(wdata_q, wstrb_q), 1'b1, 1'b0};
                `CRC_OFF_VER_LAST: ver_word_d = '{strobed(wdata_q, wstrb_q), 1'b1, 1'b1};
                `CRC_OFF_MASK:     mask_d = wstrb_q[0] ? wdata_q[2:0] : mask_q;
                default:           mask_d = mask_q;
            endcase
        end
        awready_d = !aw_hold_d;
        wready_d  = !w_hold_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CRC_RESP_OKAY;
            gen_word_q    <= '0;
            ver_word_q    <= '0;
            gen_pre_q     <= 1'b0;
            ver_pre_q     <= 1'b0;
            pre_val_q     <= 32'h00000000;
            mask_q        <= `CRC_MASK_RST;
        end
        else
        begin
            aw_hold_q     <= aw_hold_d;
            w_hold_q      <= w_hold_d;
            awaddr_q      <= awaddr_d;
            wdata_q       <= wdata_d;
            wstrb_q       <= wstrb_d;
            s_axi_awready <= awready_d;
            s_axi_wready  <= wready_d;
            s_axi_bvalid  <= bvalid_d;
            s_axi_bresp   <= bresp_d;
            gen_word_q    <= gen_word_d;
            ver_word_q    <= ver_word_d;
            gen_pre_q     <= gen_pre_d;
            ver_pre_q     <= ver_pre_d;
            pre_val_q     <= pre_val_d;
            mask_q        <= mask_d;
        end
    end

    // read path; a status read clears what it returned, new events win
    always_comb
    begin
        arready_d = s_axi_arready;
        rvalid_d  = s_axi_rvalid;
        rdata_d   = s_axi_rdata;
        rresp_d   = s_axi_rresp;
        ev.final_done = fin_q;
        ev.match      = chk_q && match;
        ev.mismatch   = chk_q && !match;
        sts_d = sts_q;
        if (s_axi_rvalid && s_axi_rready)
        begin
            rvalid_d  = 1'b0;
            arready_d = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            arready_d = 1'b0;
            rvalid_d  = 1'b1;
            rresp_d   = mapped(ra) ? `CRC_RESP_OKAY : `CRC_RESP_SLVERR;
            case (ra)
                `CRC_OFF_GEN_REM: rdata_d = gen_rem;
                `CRC_OFF_VER_REM: rdata_d = ver_rem;
                `CRC_OFF_MASK:    rdata_d = {29'h0, mask_q};
                `CRC_OFF_STATUS:
                begin
                    rdata_d = {29'h0, sts_q};
                    sts_d   = '0;
                end
                default:          rdata_d = 32'h00000000;
            endcase
        end
        sts_d = sts_d | ev;
        fin_d = gen_word_q.valid && gen_word_q.last && !gen_pre_q;
        chk_d = ver_word_q.valid && ver_word_q.last && !ver_pre_q;
        irq_d = |(sts_d & mask_d);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CRC_RESP_OKAY;
            sts_q         <= '0;
            fin_q         <= 1'b0;
            chk_q         <= 1'b0;
            irq           <= 1'b0;
        end
        else
        begin
            s_axi_arready <= arready_d;
            s_axi_rvalid  <= rvalid_d;
            s_axi_rdata   <= rdata_d;
            s_axi_rresp   <= rresp_d;
            sts_q         <= sts_d;
            fin_q         <= fin_d;
            chk_q         <= chk_d;
            irq           <= irq_d;
        end
    end
endmodule

`default_nettype wire

// [tb/remainder_out_aal5_sva.sv]
/*
 * Checker for the bus handshakes and the interrupt line of the crc block.
 * Assumes it is bound to the top module with one clock and a sync reset.
 */
`timescale 1ns/1ns
`default_nettype none
module remainder_out_aal5_sva
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // idle state right after reset, answer timing, holding and blocking
    reset_idle_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_wready
        && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs not idle after reset");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    write_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken while one is held");
    wdata_block_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("second write data taken while one is held");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    resp_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
endmodule
bind remainder_out_aal5_gen_verify remainder_out_aal5_sva i_sva (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq);
`default_nettype wire

// [tb/sar_feeder.sv]
/*
 * Feeding logic model: a bus master that hands packet words to the block.
 * Assumes the bus slave answers in its own time; slow delays the master's ready for the answers.
 */
`timescale 1ns/1ns
`default_nettype none
module sar_feeder
(
    input  wire logic        aclk,
    input  wire logic        slow,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // idle bus at time zero
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = {8'h0, 1'h0, 2'h3};
    end

    // each channel drops its valid once taken; a slow master takes the answer late
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= !slow;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready)
                break;
            if (s_axi_bvalid)
                s_axi_bready <= 1'h1;
        end
        r = s_axi_bresp;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= !slow;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready)
                break;
            if (s_axi_rvalid)
                s_axi_rready <= 1'h1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // preload before a packet, or a saved remainder when resuming one
    task start(input logic [7:0] base, input logic [31:0] v);
        logic [1:0] r;
        wr(base, v, r);
    endtask

    // one write is one valid word; the last one carries the one-cycle request
    task word(input logic [7:0] base, input logic [31:0] d, input logic last);
        logic [1:0] r;
        wr(base + (last ? 8'h08 : 8'h04), d, r);
    endtask
endmodule
`default_nettype wire

// [tb/remainder_out_aal5_gen_verify_tb.sv]
/*
 * Testbench: packets through generator and verifier over the register bus.
 * Assumes the checker is bound by its own file and the feeder masters the bus.
 */
`timescale 1ns/1ns
`default_nettype none
module remainder_out_aal5_gen_verify_tb;
    logic        aclk;
    logic        aresetn;
    logic        slow;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, c, s, v;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic [31:0] w [3] = '{32'h01234567, 32'h89abcdef, 32'h0badf00d};
    int          errors = 0;
    int          n_checks = 0;

    remainder_out_aal5_gen_verify i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    sar_feeder i_feed (.aclk, .slow, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    // own reference update, msb first, kept apart from the design's
    function automatic logic [31:0] step(input logic [31:0] x, input logic [31:0] d);
        for (int i = 31; i >= 0; i--)
            x = {x[30:0], 1'h0} ^ ((x[31] ^ d[i]) ? 32'h04c11db7 : 32'h0);
        return x;
    endfunction

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        i_feed.rd(a, v, r);
        chk(v, exp);
    endtask

    task end_of_test;
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // free-running 100 MHz clock
    initial
    begin
        aclk = 1'h0;
        forever
            #5 aclk = ~aclk;
    end

    // a hang counts as a mismatch; the run needs far less
    initial
    begin
        #100000;
        errors++;
        end_of_test();
    end

    // main sequence
    initial
    begin
        aresetn = 1'h0;
        slow    = 1'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        foreach (w[i]) rchk(8'h0c + 8'(i * 16), 32'h0);
        i_feed.wr(8'h24, 32'hffffffff, r);
        rchk(8'h24, 32'h7);
        i_feed.start(8'h00, 32'hffffffff);
        rchk(8'h0c, 32'hffffffff);
        c = 32'hffffffff;
        for (int i = 0; i < 2; i++)
        begin
            i_feed.word(8'h00, w[i], 1'h0);
            c = step(c, w[i]);
            rchk(8'h0c, c);
        end
        i_feed.word(8'h00, w[2], 1'h1);
        c = ~step(c, w[2]);
        rchk(8'h0c, c);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rchk(8'h20, 32'h1);
        rchk(8'h20, 32'h0);
        chk({31'h0, irq}, 32'h0);
        i_feed.wr(8'h24, 32'h2, r);
        // corrupt trailer first, then the good one; only a match is unmasked
        for (int k = 1; k >= 0; k--)
        begin
            i_feed.start(8'h10, 32'hffffffff);
            foreach (w[i]) i_feed.word(8'h10, w[i], 1'h0);
            i_feed.word(8'h10, c ^ 32'(k), 1'h1);
            repeat (3) @(posedge aclk);
            chk({31'h0, irq}, 32'(k == 0));
            rchk(8'h20, k ? 32'h4 : 32'h2);
        end
        rchk(8'h1c, 32'hc704dd7b);
        i_feed.wr(8'h3c, 32'h1, r);
        chk({30'h0, r}, 32'h2);
        i_feed.rd(8'h3c, v, r);
        chk({v[31:2], r}, 32'h2);
        i_feed.wr(8'h0c, 32'h5, r);
        chk({30'h0, r}, 32'h0);
        rchk(8'h0c, ~c);
        // interleaved packets with a slow master
        slow <= 1'h1;
        i_feed.start(8'h00, 32'hffffffff);
        i_feed.word(8'h00, w[0], 1'h0);
        i_feed.rd(8'h0c, s, r);
        chk(s, step(32'hffffffff, w[0]));
        i_feed.start(8'h00, 32'h0);
        i_feed.word(8'h00, w[1], 1'h0);
        rchk(8'h0c, step(32'h0, w[1]));
        i_feed.start(8'h00, s);
        i_feed.word(8'h00, w[1], 1'h0);
        rchk(8'h0c, step(s, w[1]));
        rchk(8'h1c, 32'hc704dd7b);
        end_of_test();
    end
endmodule
`default_nettype wire
